// >>> design/smc_pkg.sv
// package for the system mode clock control block
// assumes a single 40 MHz clock domain and an AXI4-Lite register bus
package smc_pkg;
    // register byte offsets
    localparam logic [7:0] SMC_OFF_MODE = 8'h00;
    localparam logic [7:0] SMC_OFF_STAT = 8'h04;
    localparam logic [7:0] SMC_OFF_MASK = 8'h08;
    localparam logic [7:0] SMC_OFF_CTRL = 8'h0c;
    // mode register field positions
    localparam int SMC_B_CLKSEL = 0;
    localparam int SMC_B_IDLE_ON_HALT = 1;
    localparam int SMC_B_HRDY = 2;
    localparam int SMC_B_LRDY = 3;
    localparam int SMC_B_FAST = 4;
    // control register field positions
    localparam int SMC_B_SYSON = 0;
    localparam int SMC_B_HALT = 1;
    localparam int SMC_B_WAKE = 2;
    localparam int SMC_B_HTYPE = 4;
    localparam int SMC_B_LTYPE = 6;
    // status register event bits
    localparam int SMC_E_HRDY = 0;
    localparam int SMC_E_LRDY = 1;
    localparam int SMC_E_HALT = 2;
    // reset values
    localparam logic [7:0] SMC_MODE_RST = 8'h03;
    localparam logic [7:0] SMC_CTRL_RST = 8'h00;
    // oscillator settle counts in oscillator cycles
    localparam int SMC_CRYSTAL_CYC = 1024;
    localparam int SMC_RC_CYC = 16;
    localparam int SMC_INTERNAL_LOW_RC_CYC = 2;
    // axi responses
    localparam logic [1:0] SMC_RESP_OK = 2'b00;
    localparam logic [1:0] SMC_RESP_ERR = 2'b10;
    // high speed oscillator types
    typedef enum logic [1:0] {
        SMC_HXT = 2'b00,
        SMC_ERC = 2'b01,
        SMC_INTERNAL_HIGH_RC = 2'b10
    } smc_htype_t;
    // power modes
    typedef enum logic [1:0] {
        SMC_RUN = 2'b00,
        SMC_IDLE_RUN = 2'b01,
        SMC_IDLE_STOP = 2'b10,
        SMC_SLEEP = 2'b11
    } smc_mode_t;
    // clock status carried together
    typedef struct packed {
        logic sys_fast;
        logic sub_temp;
        logic cpu_run;
        logic hosc_on;
    } smc_clk_t;
endpackage : smc_pkg

// >>> design/smc_top.sv
// system mode clock control: mode register, ready flags, halt modes
// assumes AXI4-Lite master, oscillator cycles counted on CLK_IN
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Contract
// - fast wake bit set: run from sub clock right after wake-up
// - fast wake applies only when external high crystal is selected
// - sub clock is used to shorten wake-up while main osc settles
// - read-only low-speed ready flag shows stability after reset or wake
// - low ready low in sleep; high after 1024 or 1..2 cycles
// - high ready flag cleared at power-on, set when osc stable
// - after power-on completes, high ready flag reads one
// - high ready low in sleep and stopped idle; 1024 or 15..16 cycles
// - idle bit set plus halt: idle; clock-on keeps system clock
// - idle with clock-on low stops cpu and system clock
// - idle bit clear plus halt: sleep mode
// - select low: divided or low-speed clock; low-speed stops high osc
module smc_top
    import smc_pkg::*;
#(
    parameter int CRYSTAL_CYC = SMC_CRYSTAL_CYC
)(
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic [7:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [7:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    input wire logic WAKE_IN,
    input wire logic LOW_DIV_IN,
    output logic [3:0] CLK_STATE_OUT,
    output logic [1:0] MODE_OUT,
    output logic IRQ_OUT
);
    logic [7:0] ctrl_reg;
    logic clksel_reg, idle_on_halt_reg, fast_reg;
    logic hrdy_reg, lrdy_reg;
    logic [10:0] hcnt_reg, lcnt_reg;
    logic [2:0] stat_reg, mask_reg;
    smc_mode_t mode_reg;
    smc_clk_t clk_next;
    logic aw_got_reg, w_got_reg;
    logic [7:0] aw_reg;
    logic [31:0] w_reg;
    logic [3:0] ws_reg;
    logic wr_go, halt_go, wake_go, hrdy_rise, lrdy_rise;
    logic [10:0] hlimit, llimit;
    smc_htype_t htype;
    logic ltype_internal_low_rc;

    // settle count limit for a high speed oscillator type
    function automatic logic [10:0] hlim(input smc_htype_t t);
        hlim = (t == SMC_HXT) ? 11'(CRYSTAL_CYC) : 11'(SMC_RC_CYC);
    endfunction : hlim

    assign htype = smc_htype_t'(ctrl_reg[SMC_B_HTYPE +: 2]);
    assign ltype_internal_low_rc = ctrl_reg[SMC_B_LTYPE];
    assign hlimit = hlim(htype);
    assign llimit = ltype_internal_low_rc ? 11'(SMC_INTERNAL_LOW_RC_CYC) : 11'(CRYSTAL_CYC);

    // write channel capture, either order
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_reg <= 8'h00;
            w_reg <= 32'h0;
            ws_reg <= 4'h0;
            BVALID_OUT <= 1'b0;
            BRESP_OUT <= SMC_RESP_OK;
        end
        else
        begin
            if (AWVALID_IN && AWREADY_OUT)
            begin
                aw_got_reg <= 1'b1;
                aw_reg <= AWADDR_IN;
            end
            if (WVALID_IN && WREADY_OUT)
            begin
                w_got_reg <= 1'b1;
                w_reg <= WDATA_IN;
                ws_reg <= WSTRB_IN;
            end
            if (wr_go)
            begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                BVALID_OUT <= 1'b1;
                BRESP_OUT <= (aw_reg[7:4] == 4'h0) ? SMC_RESP_OK : SMC_RESP_ERR;
            end
            else if (BVALID_OUT && BREADY_IN)
                BVALID_OUT <= 1'b0;
        end
    end
    assign wr_go = aw_got_reg && w_got_reg && !BVALID_OUT;

    // ready outputs registered
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            AWREADY_OUT <= 1'b0;
            WREADY_OUT <= 1'b0;
            ARREADY_OUT <= 1'b0;
        end
        else
        begin
            AWREADY_OUT <= !aw_got_reg && !(AWVALID_IN && AWREADY_OUT) && !BVALID_OUT;
            WREADY_OUT <= !w_got_reg && !(WVALID_IN && WREADY_OUT) && !BVALID_OUT;
            ARREADY_OUT <= !RVALID_OUT && !(ARVALID_IN && ARREADY_OUT);
        end
    end

    // software control fields; halt pulses come from ctrl writes, wake from ctrl writes or WAKE_IN
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            clksel_reg <= SMC_MODE_RST[SMC_B_CLKSEL];
            idle_on_halt_reg <= SMC_MODE_RST[SMC_B_IDLE_ON_HALT];
            fast_reg <= SMC_MODE_RST[SMC_B_FAST];
            ctrl_reg <= SMC_CTRL_RST;
            mask_reg <= 3'h0;
        end
        else if (wr_go && ws_reg[0])
        begin
            unique case (aw_reg)
                SMC_OFF_MODE:
                begin
                    clksel_reg <= w_reg[SMC_B_CLKSEL];
                    idle_on_halt_reg <= w_reg[SMC_B_IDLE_ON_HALT];
                    fast_reg <= w_reg[SMC_B_FAST];
                end
                SMC_OFF_MASK: mask_reg <= w_reg[2:0];
                SMC_OFF_CTRL: ctrl_reg <= {w_reg[7:3], 1'b0, 1'b0, w_reg[0]};
                default: ;
            endcase
        end
    end
    assign halt_go = wr_go && ws_reg[0] && aw_reg == SMC_OFF_CTRL && w_reg[SMC_B_HALT]
        && mode_reg == SMC_RUN;
    assign wake_go = (WAKE_IN || (wr_go && ws_reg[0] && aw_reg == SMC_OFF_CTRL
        && w_reg[SMC_B_WAKE])) && mode_reg != SMC_RUN;

    // power mode on halt and wake
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            mode_reg <= SMC_RUN;
        else if (halt_go)
        begin
            if (!idle_on_halt_reg)
                mode_reg <= SMC_SLEEP;
            else if (ctrl_reg[SMC_B_SYSON])
                mode_reg <= SMC_IDLE_RUN;
            else
                mode_reg <= SMC_IDLE_STOP;
        end
        else if (wake_go)
            mode_reg <= SMC_RUN;
    end

    // high ready flag: cleared at reset, low in sleep and stopped idle
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            hrdy_reg <= 1'b0;
            hcnt_reg <= 11'h0;
        end
        else if (mode_reg == SMC_SLEEP || mode_reg == SMC_IDLE_STOP
            || (!clksel_reg && LOW_DIV_IN))
        begin
            hrdy_reg <= 1'b0;
            hcnt_reg <= 11'h0;
        end
        else if (!hrdy_reg)
        begin
            hcnt_reg <= hcnt_reg + 11'h1;
            if (hcnt_reg + 11'h1 >= hlimit)
                hrdy_reg <= 1'b1;
        end
    end

    // low ready flag: cleared at reset and in full sleep, not in idle
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            lrdy_reg <= 1'b0;
            lcnt_reg <= 11'h0;
        end
        else if (mode_reg == SMC_SLEEP)
        begin
            lrdy_reg <= 1'b0;
            lcnt_reg <= 11'h0;
        end
        else if (!lrdy_reg)
        begin
            lcnt_reg <= lcnt_reg + 11'h1;
            if (lcnt_reg + 11'h1 >= llimit)
                lrdy_reg <= 1'b1;
        end
    end

    // sticky events, set wins over write-one clear
    assign hrdy_rise = !hrdy_reg && hcnt_reg + 11'h1 >= hlimit && mode_reg != SMC_SLEEP
        && mode_reg != SMC_IDLE_STOP && !(!clksel_reg && LOW_DIV_IN);
    assign lrdy_rise = !lrdy_reg && lcnt_reg + 11'h1 >= llimit && mode_reg != SMC_SLEEP;
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            stat_reg <= 3'h0;
        else
        begin
            stat_reg <= (stat_reg & ~((wr_go && ws_reg[0] && aw_reg == SMC_OFF_STAT)
                ? w_reg[2:0] : 3'h0)) | {halt_go, lrdy_rise, hrdy_rise};
        end
    end

    // clock steering
    always_comb
    begin
        clk_next.cpu_run = (mode_reg == SMC_RUN);
        clk_next.hosc_on = !(mode_reg == SMC_SLEEP || mode_reg == SMC_IDLE_STOP)
            && !(!clksel_reg && LOW_DIV_IN);
        clk_next.sub_temp = fast_reg && htype == SMC_HXT && mode_reg == SMC_RUN
            && !hrdy_reg && lrdy_reg;
        clk_next.sys_fast = clksel_reg && hrdy_reg && !clk_next.sub_temp;
    end

    // registered outputs
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            CLK_STATE_OUT <= 4'h0;
            MODE_OUT <= SMC_RUN;
            IRQ_OUT <= 1'b0;
        end
        else
        begin
            CLK_STATE_OUT <= clk_next;
            MODE_OUT <= mode_reg;
            IRQ_OUT <= |(stat_reg & mask_reg);
        end
    end

    // read channel
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            RVALID_OUT <= 1'b0;
            RDATA_OUT <= 32'h0;
            RRESP_OUT <= SMC_RESP_OK;
        end
        else if (ARVALID_IN && ARREADY_OUT)
        begin
            RVALID_OUT <= 1'b1;
            RRESP_OUT <= SMC_RESP_OK;
            unique case (ARADDR_IN)
                SMC_OFF_MODE: RDATA_OUT <= {27'h0, fast_reg, lrdy_reg, hrdy_reg,
                    idle_on_halt_reg, clksel_reg};
                SMC_OFF_STAT: RDATA_OUT <= {29'h0, stat_reg};
                SMC_OFF_MASK: RDATA_OUT <= {29'h0, mask_reg};
                SMC_OFF_CTRL: RDATA_OUT <= {24'h0, ctrl_reg};
                default:
                begin
                    RDATA_OUT <= 32'h0;
                    RRESP_OUT <= SMC_RESP_ERR;
                end
            endcase
        end
        else if (RVALID_OUT && RREADY_IN)
            RVALID_OUT <= 1'b0;
    end

    chk_sleep_flags: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        mode_reg == SMC_SLEEP |=> !hrdy_reg && !lrdy_reg) else $error("flags high in sleep");
    chk_idle_stop_h: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        mode_reg == SMC_IDLE_STOP |=> !hrdy_reg) else $error("high flag in stopped idle");
    chk_halt_sleep: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        halt_go && !idle_on_halt_reg |=> mode_reg == SMC_SLEEP) else $error("halt no sleep");
    chk_halt_idle_run: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        halt_go && idle_on_halt_reg && ctrl_reg[0] |=> mode_reg == SMC_IDLE_RUN)
        else $error("halt no idle run");
    chk_halt_idle_stop: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        halt_go && idle_on_halt_reg && !ctrl_reg[0] |=> mode_reg == SMC_IDLE_STOP)
        else $error("halt no idle stop");
    chk_fast_only_hxt: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        clk_next.sub_temp |-> fast_reg && htype == SMC_HXT) else $error("bad fast wake");
    chk_fast_used: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        fast_reg && htype == SMC_HXT && mode_reg == SMC_RUN && !hrdy_reg && lrdy_reg
        |-> ##1 CLK_STATE_OUT[2]) else $error("sub clock not used");
    chk_select_fast: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !clksel_reg |=> !CLK_STATE_OUT[3]) else $error("fast clock while deselected");
    chk_low_stops_h: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        !clksel_reg && LOW_DIV_IN |=> !hrdy_reg) else $error("high osc kept");
    chk_internal_low_rc_ready: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        $fell(mode_reg == SMC_SLEEP) && ltype_internal_low_rc |-> ##[1:3] lrdy_reg)
        else $error("internal_low_rc ready late");
endmodule : smc_top

// >>> test/smc_top_bench.sv
// bench for the system mode clock control block
// assumes smc_top and smc_pkg compiled first, AXI4-Lite driven from here
`timescale 1ns/1ps
module smc_top_bench;
    import smc_pkg::*;
    localparam int CRY = 16; // shortened crystal settle count
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic wake = 1'b0, low_div = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, mode;
    logic [31:0] rdata, rd;
    logic [3:0] clk_state;
    int fails = 0;
    int comparisons = 0;
    smc_top #(.CRYSTAL_CYC(CRY)) u_smc_top (
        .CLK_IN(clk), .RST_B_IN(rst_b),
        .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
        .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready),
        .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
        .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
        .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
        .WAKE_IN(wake), .LOW_DIV_IN(low_div),
        .CLK_STATE_OUT(clk_state), .MODE_OUT(mode), .IRQ_OUT(irq)
    );
    // 40 MHz clock
    always #12.5 clk = ~clk;
    // compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // verdict and end of run
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    // one write: address and data offered together, each released when taken;
    // handshakes are judged on values settled at the falling edge before each rise
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_hit, w_hit, b_hit;
        logic [1:0] resp;
        aw_hit = 1'b0;
        w_hit = 1'b0;
        b_hit = 1'b0;
        resp = 2'b00;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hit)
        begin
            @(negedge clk);
            aw_hit = awvalid && awready === 1'b1;
            w_hit = wvalid && wready === 1'b1;
            b_hit = bvalid === 1'b1;
            resp = bresp;
            @(posedge clk);
            if (aw_hit)
                awvalid <= 1'b0;
            if (w_hit)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
        check({30'h0, resp}, {30'h0, er});
        @(posedge clk);
    endtask : axi_write
    // one read: result lands in rd, response code checked against er
    task automatic axi_read(input logic [7:0] a, input logic [1:0] er);
        logic ar_hit, r_hit;
        logic [1:0] resp;
        ar_hit = 1'b0;
        r_hit = 1'b0;
        resp = 2'b00;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_hit)
        begin
            @(negedge clk);
            ar_hit = arvalid && arready === 1'b1;
            r_hit = rvalid === 1'b1;
            rd = rdata;
            resp = rresp;
            @(posedge clk);
            if (ar_hit)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
        check({30'h0, resp}, {30'h0, er});
        @(posedge clk);
    endtask : axi_read
    // one-cycle wake request
    task automatic pulse_wake();
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse_wake
    // control fields first, so the halt that follows sees them in place
    task automatic halt(input logic [7:0] ctrl, input logic [1:0] exp_mode);
        axi_write(SMC_OFF_CTRL, {24'h0, ctrl & 8'hfd}, SMC_RESP_OK);
        axi_write(SMC_OFF_CTRL, {24'h0, ctrl}, SMC_RESP_OK);
        repeat (2) @(posedge clk);
        check({30'h0, mode}, {30'h0, exp_mode});
    endtask : halt
    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end
    // test sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        axi_read(SMC_OFF_MODE, SMC_RESP_OK);
        check(rd, 32'h03);
        repeat (1100) @(posedge clk);
        axi_read(SMC_OFF_MODE, SMC_RESP_OK);
        check(rd, 32'h0f);
        axi_read(8'h10, SMC_RESP_ERR);
        check(rd, 32'h0);
        axi_write(8'h14, 32'h1, SMC_RESP_ERR);
        $display("test reset and map done");
        // select bit and low-speed choice
        check({31'h0, clk_state[3]}, 32'h1);
        axi_write(SMC_OFF_MODE, 32'h02, SMC_RESP_OK);
        repeat (2) @(posedge clk);
        check({30'h0, clk_state[3], clk_state[0]}, 32'h1);
        low_div <= 1'b1;
        repeat (3) @(posedge clk);
        check({31'h0, clk_state[0]}, 32'h0);
        low_div <= 1'b0;
        axi_write(SMC_OFF_MODE, 32'h03, SMC_RESP_OK);
        repeat (CRY + 4) @(posedge clk);
        $display("test clock select done");
        // idle with clock kept running, with interrupt on halt event
        axi_write(SMC_OFF_STAT, 32'h07, SMC_RESP_OK);
        axi_write(SMC_OFF_MASK, 32'h04, SMC_RESP_OK);
        halt(8'h03, SMC_IDLE_RUN);
        check({31'h0, clk_state[1]}, 32'h0);
        check({31'h0, irq}, 32'h1);
        axi_read(SMC_OFF_MODE, SMC_RESP_OK);
        check(rd & 32'h04, 32'h04);
        pulse_wake();
        check({30'h0, mode}, {30'h0, SMC_RUN});
        axi_write(SMC_OFF_STAT, 32'h04, SMC_RESP_OK);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        axi_write(SMC_OFF_MASK, 32'h00, SMC_RESP_OK);
        $display("test idle running done");
        // idle with clock stopped, fast wake from the sub clock on crystal
        axi_write(SMC_OFF_MODE, 32'h13, SMC_RESP_OK);
        halt(8'h02, SMC_IDLE_STOP);
        check({31'h0, irq}, 32'h0);
        axi_read(SMC_OFF_MODE, SMC_RESP_OK);
        check(rd & 32'h04, 32'h0);
        pulse_wake();
        check({31'h0, clk_state[2]}, 32'h1);
        repeat (CRY + 4) @(posedge clk);
        check({31'h0, clk_state[2]}, 32'h0);
        axi_read(SMC_OFF_MODE, SMC_RESP_OK);
        check(rd & 32'h04, 32'h04);
        // same with an rc oscillator: fast wake has no effect
        halt(8'h12, SMC_IDLE_STOP);
        pulse_wake();
        check({31'h0, clk_state[2]}, 32'h0);
        repeat (18) @(posedge clk);
        axi_read(SMC_OFF_MODE, SMC_RESP_OK);
        check(rd & 32'h04, 32'h04);
        $display("test fast wake done");
        // sleep with internal low rc, then with external low crystal
        axi_write(SMC_OFF_MODE, 32'h01, SMC_RESP_OK);
        halt(8'h42, SMC_SLEEP);
        axi_read(SMC_OFF_MODE, SMC_RESP_OK);
        check(rd & 32'h08, 32'h0);
        pulse_wake();
        repeat (2) @(posedge clk);
        axi_read(SMC_OFF_MODE, SMC_RESP_OK);
        check(rd & 32'h08, 32'h08);
        halt(8'h02, SMC_SLEEP);
        // wake by the control register's wake bit this time
        axi_write(SMC_OFF_CTRL, 32'h04, SMC_RESP_OK);
        check({30'h0, mode}, {30'h0, SMC_RUN});
        axi_read(SMC_OFF_MODE, SMC_RESP_OK);
        check(rd & 32'h08, 32'h0);
        repeat (1030) @(posedge clk);
        axi_read(SMC_OFF_MODE, SMC_RESP_OK);
        check(rd & 32'h08, 32'h08);
        $display("test sleep done");
        summarize();
    end
endmodule : smc_top_bench
